// >>> hw/ufc_consts.svh
// register offsets, field positions, reset values and levels of the flow-control block
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
`define UFC_OFS_FCTL 8'h00
`define UFC_OFS_FEAT 8'h04
`define UFC_OFS_THLD 8'h08
`define UFC_OFS_PTRG 8'h0c
`define UFC_OFS_MCTL 8'h10
`define UFC_OFS_IEN 8'h14
`define UFC_OFS_IID 8'h18
`define UFC_OFS_LCR 8'h1c
`define UFC_OFS_HC1 8'h20
`define UFC_OFS_HC2 8'h24
`define UFC_OFS_RC1 8'h28
`define UFC_OFS_RC2 8'h2c
`define UFC_OFS_STS 8'h30
`define UFC_LCR_RST 8'h1d
`define UFC_IID_NONE 8'h01
`define UFC_IID_OFF 8'h10
`define UFC_FEAT_ACTS 7
`define UFC_FEAT_ARTS 6
`define UFC_FEAT_SPEC 5
`define UFC_MCTL_ANY 5
`define UFC_MCTL_RTS 1
`define UFC_IEN_OFF 5
`define UFC_FCTL_EN 0
`define UFC_RX_L0 7'h08
`define UFC_RX_L1 7'h10
`define UFC_RX_L2 7'h38
`define UFC_RX_L3 7'h3c
`define UFC_RX_LOW0 7'h04
`define UFC_TX_L0 7'h08
`define UFC_TX_L1 7'h10
`define UFC_TX_L2 7'h20
`define UFC_TX_L3 7'h38
`define UFC_ONE_CHAR 7'h01
`endif

// >>> hw/ufc_pkg.sv
// shared types of the flow-control block
package ufc_pkg;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ufc_char_t;
   typedef enum logic [1:0] {
      UFC_IDLE,
      UFC_SEND1,
      UFC_SEND2
   } ufc_ins_st_t;
endpackage

// >>> hw/ufc_flow.sv
// uart flow control: trigger levels, auto rts/cts, in-band halt/resume characters
// Operation
// (R1) after reset fifos off, so both trigger levels read as one character
// (R2) nonzero programmable trigger register overrides the selectable fifo control level
// (R3) enhanced bits 7 and 6 enable auto cts and auto rts separately
// (R4) with auto cts, a character starts only while cts is active low
// (R5) remote drops cts before mid last stop bit to stop the next character
// (R6) with auto cts on, cts changes raise no host event
// (R7) auto rts active below halt level in threshold low nibble, drops at it
// (R8) after halt, rts returns once occupancy falls to the resume level
// (R9) zero threshold register means selectable fifo levels supply halt and resume
// (R10) a character arriving after rts drops is still stored
// (R11) enhanced bits 3:2 choose sent flow characters: none, first, second, both
// (R12) enhanced bits 1:0 choose compared pair: none, first, second
// (R13) bits 1:0 both set: either char with one tx pair, sequence otherwise
// (R14) modem control bit 5 lets any received character resume a halted transmitter
// (R15) special mode: second halt char raises off interrupt, is stored, no halt
// (R16) off sequence: current character finishes, then transmitter halts
// (R17) off detect sets ident bit 4 and pulls irq low when enabled
// (R18) on sequence resumes transmitter and clears the off interrupt
// (R19) send halt characters when occupancy passes halt or selectable level
// (R20) send resume characters at resume level or below lower selectable level
// (R21) flow characters framed like data, masked to the word length
// (R22) software never enables in-band and rts/cts flow control together
// (R23) off interrupt shows ident code 01 0000, priority six
// (R24) threshold and programmable trigger registers reset to zero
// (R25) thresholds compare against current occupancy every cycle
`timescale 1ns/1ps
`include "ufc_consts.svh"
module ufc_flow
   import ufc_pkg::*;
#(
   parameter int CNT_W = 7
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [CNT_W-1:0] i_rx_count,
   input wire ufc_char_t i_rx_char,
   output ufc_char_t o_rx_store,
   input wire logic i_cts_n,
   output logic o_rts_n,
   output logic o_cts_event,
   output logic o_tx_go,
   output ufc_char_t o_ins,
   input wire logic i_ins_taken,
   output logic o_irq_n,
   output logic [CNT_W-1:0] o_rx_trig,
   output logic [CNT_W-1:0] o_tx_trig
);
   logic [7:0] fctl_q, feat_q, thld_q, ptrg_q, mctl_q, ien_q, lcr_q;
   logic [7:0] hc1_q, hc2_q, rc1_q, rc2_q;
   logic [31:0] rdata_d;
   logic pready_q, slverr_d, wr_go, rd_go, iid_rd;
   logic cts_s1_q, cts_s2_q, cts_s3_q, cts_f_q;
   logic rts_act_q, halted_q, xoff_int_q, spec_int_q;
   logic off_arm_q, on_arm_q, xoff_sent_q, kind_off_q;
   ufc_ins_st_t ins_st_q;
   logic [CNT_W-1:0] rx_sel, rx_low, tx_sel, halt_lvl, res_lvl;
   logic [7:0] wmask, iid_val;
   logic [1:0] rxm, txm;
   logic seqm, m_h1, m_h2, m_r1, m_r2, off_det, on_det, flow, special, any_res;
   logic res_hit, send_off, send_on;

   // apb: one wait state so read data can come from a flop
   assign wr_go = i_psel & i_penable & pready_q & i_pwrite;
   assign rd_go = i_psel & i_penable & ~pready_q & ~i_pwrite;
   assign iid_rd = i_psel & i_penable & pready_q & ~i_pwrite & (i_paddr == `UFC_OFS_IID);
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= i_psel & i_penable & ~pready_q;
      end
   end
   assign o_pready = pready_q;

   // off interrupt code when pending and enabled
   assign iid_val = ((xoff_int_q | spec_int_q) & ien_q[`UFC_IEN_OFF]) ? `UFC_IID_OFF : `UFC_IID_NONE; // [R23]

   // read mux, unmapped addresses answer with an error and zero data
   always_comb begin
      rdata_d = 32'h0000_0000;
      slverr_d = 1'b0;
      unique case (i_paddr)
         `UFC_OFS_FCTL: rdata_d[7:0] = fctl_q;
         `UFC_OFS_FEAT: rdata_d[7:0] = feat_q;
         `UFC_OFS_THLD: rdata_d[7:0] = thld_q;
         `UFC_OFS_PTRG: rdata_d[7:0] = ptrg_q;
         `UFC_OFS_MCTL: rdata_d[7:0] = mctl_q;
         `UFC_OFS_IEN: rdata_d[7:0] = ien_q;
         `UFC_OFS_IID: rdata_d[7:0] = iid_val;
         `UFC_OFS_LCR: rdata_d[7:0] = lcr_q;
         `UFC_OFS_HC1: rdata_d[7:0] = hc1_q;
         `UFC_OFS_HC2: rdata_d[7:0] = hc2_q;
         `UFC_OFS_RC1: rdata_d[7:0] = rc1_q;
         `UFC_OFS_RC2: rdata_d[7:0] = rc2_q;
         `UFC_OFS_STS: rdata_d[7:0] = {3'b000, xoff_sent_q, spec_int_q, xoff_int_q, rts_act_q, halted_q};
         default: slverr_d = 1'b1;
      endcase
   end

   // read data and error are captured in the wait cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel & i_penable & ~pready_q) begin
         o_prdata <= rd_go ? rdata_d : 32'h0000_0000;
         o_pslverr <= slverr_d;
      end
   end

   // control registers; flow characters are not reset so they keep their values
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fctl_q <= 8'h00; // [R1]
         feat_q <= 8'h00;
         thld_q <= 8'h00; // [R24]
         ptrg_q <= 8'h00; // [R24]
         mctl_q <= 8'h00;
         ien_q <= 8'h00;
         lcr_q <= `UFC_LCR_RST;
      end else if (wr_go) begin
         if (i_paddr == `UFC_OFS_FCTL) fctl_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_FEAT) feat_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_THLD) thld_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_PTRG) ptrg_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_MCTL) mctl_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_IEN) ien_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_LCR) lcr_q <= i_pwdata[7:0];
      end
   end
   always_ff @(posedge i_clk) begin
      if (wr_go) begin
         if (i_paddr == `UFC_OFS_HC1) hc1_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_HC2) hc2_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_RC1) rc1_q <= i_pwdata[7:0];
         if (i_paddr == `UFC_OFS_RC2) rc2_q <= i_pwdata[7:0];
      end
   end

   // selectable levels and the lower neighbour used for the resume fallback
   always_comb begin
      unique case (fctl_q[7:6])
         2'b00: begin rx_sel = `UFC_RX_L0; rx_low = `UFC_RX_LOW0; end
         2'b01: begin rx_sel = `UFC_RX_L1; rx_low = `UFC_RX_L0; end
         2'b10: begin rx_sel = `UFC_RX_L2; rx_low = `UFC_RX_L1; end
         2'b11: begin rx_sel = `UFC_RX_L3; rx_low = `UFC_RX_L2; end
      endcase
      unique case (fctl_q[5:4])
         2'b00: tx_sel = `UFC_TX_L0;
         2'b01: tx_sel = `UFC_TX_L1;
         2'b10: tx_sel = `UFC_TX_L2;
         2'b11: tx_sel = `UFC_TX_L3;
      endcase
   end

   // zero threshold register falls back to the selectable level
   assign halt_lvl = (thld_q == 8'h00) ? rx_sel : {1'b0, thld_q[3:0], 2'b00}; // [R9]
   assign res_lvl = {1'b0, thld_q[7:4], 2'b00};
   assign res_hit = (thld_q == 8'h00) ? (i_rx_count < rx_low) : (i_rx_count <= res_lvl); // [R9] [R25]

   // trigger levels: one char while fifos are off, programmable nibble wins when nonzero
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rx_trig <= `UFC_ONE_CHAR; // [R1]
         o_tx_trig <= `UFC_ONE_CHAR;
      end else if (!fctl_q[`UFC_FCTL_EN]) begin
         o_rx_trig <= `UFC_ONE_CHAR; // [R1]
         o_tx_trig <= `UFC_ONE_CHAR;
      end else begin
         o_rx_trig <= (ptrg_q[3:0] != 4'h0) ? {1'b0, ptrg_q[3:0], 2'b00} : rx_sel; // [R2]
         o_tx_trig <= (ptrg_q[7:4] != 4'h0) ? {1'b0, ptrg_q[7:4], 2'b00} : tx_sel; // [R2]
      end
   end

   // cts pin filter; a level counts once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cts_s1_q <= 1'b1;
         cts_s2_q <= 1'b1;
         cts_s3_q <= 1'b1;
         cts_f_q <= 1'b1;
      end else begin
         cts_s1_q <= i_cts_n;
         cts_s2_q <= cts_s1_q;
         cts_s3_q <= cts_s2_q;
         if (cts_s2_q == cts_s3_q) cts_f_q <= cts_s3_q;
      end
   end

   // cts change event goes to the host only when auto cts is off
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_cts_event <= 1'b0;
      end else begin
         o_cts_event <= (cts_s2_q == cts_s3_q) & (cts_s3_q != cts_f_q) & ~feat_q[`UFC_FEAT_ACTS]; // [R6]
      end
   end

   // auto rts hysteresis; the halt level wins if both compare true
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rts_act_q <= 1'b1;
      end else if (i_rx_count >= halt_lvl) begin
         rts_act_q <= 1'b0; // [R7] [R25]
      end else if (res_hit) begin
         rts_act_q <= 1'b1; // [R8]
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rts_n <= 1'b1;
      end else if (feat_q[`UFC_FEAT_ARTS]) begin
         o_rts_n <= ~((i_rx_count < halt_lvl) & (rts_act_q | res_hit)); // [R3] [R7] [R8]
      end else begin
         o_rts_n <= ~mctl_q[`UFC_MCTL_RTS];
      end
   end

   // receive comparison
   assign rxm = feat_q[1:0];
   assign txm = feat_q[3:2];
   assign seqm = (rxm == 2'b11) & ((txm == 2'b00) | (txm == 2'b11)); // [R13]
   assign m_h1 = i_rx_char.data == hc1_q;
   assign m_h2 = i_rx_char.data == hc2_q;
   assign m_r1 = i_rx_char.data == rc1_q;
   assign m_r2 = i_rx_char.data == rc2_q;
   assign special = i_rx_char.valid & feat_q[`UFC_FEAT_SPEC] & m_h2; // [R15]
   assign off_det = i_rx_char.valid & ~special & (((rxm == 2'b10) & m_h1) | ((rxm == 2'b01) & m_h2)
                  | ((rxm == 2'b11) & ~seqm & (m_h1 | m_h2)) | (seqm & off_arm_q & m_h2)); // [R12] [R13]
   assign on_det = i_rx_char.valid & (((rxm == 2'b10) & m_r1) | ((rxm == 2'b01) & m_r2)
                 | ((rxm == 2'b11) & ~seqm & (m_r1 | m_r2)) | (seqm & on_arm_q & m_r2)); // [R12] [R13]
   assign flow = i_rx_char.valid & ~special & (((rxm == 2'b10) & (m_h1 | m_r1))
               | ((rxm == 2'b01) & (m_h2 | m_r2)) | ((rxm == 2'b11) & (m_h1 | m_h2 | m_r1 | m_r2)));
   assign any_res = i_rx_char.valid & mctl_q[`UFC_MCTL_ANY] & halted_q & ~off_det; // [R14]

   // sequence mode: first char of a pair arms, the next char must finish it
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         off_arm_q <= 1'b0;
         on_arm_q <= 1'b0;
      end else if (i_rx_char.valid) begin
         off_arm_q <= seqm & m_h1; // [R13]
         on_arm_q <= seqm & m_r1; // [R13]
      end
   end

   // store data chars; rts state never blocks storing, so the late char is kept
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_rx_store <= '0;
      end else begin
         o_rx_store.valid <= i_rx_char.valid & (~flow | special); // [R10] [R15]
         o_rx_store.data <= i_rx_char.data;
      end
   end

   // halt flag; a new off detect wins over a resume in the same cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         halted_q <= 1'b0;
      end else if (off_det) begin
         halted_q <= 1'b1; // [R16]
      end else if (on_det | any_res) begin
         halted_q <= 1'b0; // [R18] [R14]
      end
   end

   // off interrupt sources; sets win over clears
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         xoff_int_q <= 1'b0;
         spec_int_q <= 1'b0;
      end else begin
         if (off_det) xoff_int_q <= 1'b1; // [R17]
         else if (on_det) xoff_int_q <= 1'b0; // [R18]
         if (special) spec_int_q <= 1'b1; // [R15]
         else if (iid_rd) spec_int_q <= 1'b0; // [R15]
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_irq_n <= 1'b1;
      end else begin
         o_irq_n <= ~((xoff_int_q | spec_int_q) & ien_q[`UFC_IEN_OFF]); // [R17]
      end
   end

   // start permission: only gates the next start, a character in flight completes
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_tx_go <= 1'b0;
      end else begin
         o_tx_go <= ~halted_q & ~(feat_q[`UFC_FEAT_ACTS] & cts_f_q) & (ins_st_q == UFC_IDLE); // [R4] [R16]
      end
   end

   // flow character insertion triggers, judged on live occupancy
   assign send_off = ~xoff_sent_q & (i_rx_count > halt_lvl); // [R19] [R25]
   assign send_on = xoff_sent_q & res_hit; // [R20]
   assign wmask = 8'hff >> (2'd3 - lcr_q[1:0]); // [R21]

   // insertion sequencer; pair 11 sends first then second
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ins_st_q <= UFC_IDLE;
         xoff_sent_q <= 1'b0;
         kind_off_q <= 1'b0;
      end else begin
         unique case (ins_st_q)
            UFC_IDLE: begin
               if ((txm != 2'b00) & (send_off | send_on)) begin
                  kind_off_q <= send_off;
                  xoff_sent_q <= send_off;
                  ins_st_q <= (txm == 2'b01) ? UFC_SEND2 : UFC_SEND1; // [R11]
               end
            end
            UFC_SEND1: begin
               if (i_ins_taken) ins_st_q <= (txm == 2'b11) ? UFC_SEND2 : UFC_IDLE; // [R11]
            end
            UFC_SEND2: begin
               if (i_ins_taken) ins_st_q <= UFC_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ins <= '0;
      end else begin
         o_ins.valid <= (ins_st_q != UFC_IDLE) & ~i_ins_taken;
         unique case (ins_st_q)
            UFC_SEND1: o_ins.data <= (kind_off_q ? hc1_q : rc1_q) & wmask; // [R21]
            UFC_SEND2: o_ins.data <= (kind_off_q ? hc2_q : rc2_q) & wmask; // [R21]
            default: o_ins.data <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_pair_first;
      (ins_st_q == UFC_SEND1) && i_ins_taken && (txm == 2'b11);
   endsequence
   sequence s_pair_second;
      (ins_st_q == UFC_SEND2) ##1 o_ins.valid;
   endsequence

   chk_rts_halt: assert property (feat_q[`UFC_FEAT_ARTS] && (i_rx_count >= halt_lvl) |=> o_rts_n) // [R7]
      else $error("rts still active at halt level");
   chk_rts_resume: assert property (feat_q[`UFC_FEAT_ARTS] && res_hit && (i_rx_count < halt_lvl) |=> !o_rts_n) // [R8]
      else $error("rts not reasserted at resume level");
   chk_cts_gate: assert property (feat_q[`UFC_FEAT_ACTS] && cts_f_q |=> !o_tx_go) // [R4]
      else $error("start allowed while cts inactive");
   chk_cts_quiet: assert property (feat_q[`UFC_FEAT_ACTS] && $past(feat_q[`UFC_FEAT_ACTS]) |-> !o_cts_event) // [R6]
      else $error("cts event under auto cts");
   chk_off_halt: assert property (off_det |=> halted_q && xoff_int_q ##1 !o_tx_go) // [R16]
      else $error("off sequence did not halt");
   chk_on_resume: assert property (on_det && !off_det |=> !halted_q && !xoff_int_q) // [R18]
      else $error("on sequence did not resume");
   chk_special_keep: assert property (special |=> o_rx_store.valid && (halted_q == $past(halted_q))) // [R15]
      else $error("special char lost or halted");
   chk_irq_drive: assert property (xoff_int_q && ien_q[`UFC_IEN_OFF] |=> !o_irq_n) // [R17]
      else $error("irq not pulled low");
   chk_iid_code: assert property (xoff_int_q && ien_q[`UFC_IEN_OFF] && rd_go && i_paddr == `UFC_OFS_IID // [R23]
      |=> o_prdata[7:0] == `UFC_IID_OFF)
      else $error("wrong off interrupt code");
   chk_trig_off: assert property (!fctl_q[`UFC_FCTL_EN] |=> o_rx_trig == `UFC_ONE_CHAR) // [R1]
      else $error("trigger not one char");
   chk_pair_order: assert property (s_pair_first |=> s_pair_second) // [R11]
      else $error("second flow char skipped");
   chk_word_mask: assert property (o_ins.valid |-> (o_ins.data & ~wmask) == 8'h00) // [R21]
      else $error("flow char exceeds word length");
endmodule

// >>> test/ufc_remote.sv
// behavioural remote uart: drives cts and received characters, takes inserted flow characters
`timescale 1ns/1ps
module ufc_remote
   import ufc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rts_n,
   input wire ufc_char_t i_ins,
   output logic o_ins_taken,
   output logic o_cts_n,
   output ufc_char_t o_rx_char
);
   int lat = 0;
   int dly = 0;
   logic [7:0] got[$];
   initial begin
      o_ins_taken = 1'b0;
      o_cts_n = 1'b1;
      o_rx_char = '0;
   end
   // take one flow character after lat wait cycles; never twice for one valid level
   always @(posedge i_clk) begin
      o_ins_taken <= 1'b0;
      if (i_ins.valid === 1'b1 && !o_ins_taken) begin
         if (dly >= lat) begin
            o_ins_taken <= 1'b1;
            got.push_back(i_ins.data);
            dly <= 0;
         end else begin
            dly <= dly + 1;
         end
      end
   end
   // cts moves just after an edge, long before any stop-bit midpoint
   task automatic set_cts(input logic lvl);
      @(posedge i_clk);
      o_cts_n <= lvl;
   endtask
   // one-cycle character pulse, sent even when rts is already inactive
   task automatic send(input logic [7:0] d);
      @(posedge i_clk);
      o_rx_char <= '{valid: 1'b1, data: d};
      @(posedge i_clk);
      o_rx_char <= '{valid: 1'b0, data: ~d}; // idle data inverted so stale values never match
   endtask
endmodule

// >>> test/uart_flow_control_bench.sv
// self-checking bench of the flow-control block against a remote uart model
`timescale 1ns/1ps
`include "ufc_consts.svh"
module uart_flow_control_bench;
   import ufc_pkg::*;
   typedef struct {logic [7:0] fctl; logic [7:0] ptrg; logic [6:0] rx; logic [6:0] tx;} ufc_row_t;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, last_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] rx_count, rx_trig, tx_trig;
   ufc_char_t rx_char, rx_store, ins;
   logic cts_n, rts_n, cts_event, tx_go, ins_taken, irq_n, evt_seen, stored;
   logic [7:0] sdata;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   ufc_row_t rows[6] = '{'{8'h00, 8'h00, `UFC_ONE_CHAR, `UFC_ONE_CHAR}, '{8'h01, 8'h00, `UFC_RX_L0, `UFC_TX_L0},
      '{8'h51, 8'h00, `UFC_RX_L1, `UFC_TX_L1}, '{8'ha1, 8'h00, `UFC_RX_L2, `UFC_TX_L2},
      '{8'hf1, 8'h00, `UFC_RX_L3, `UFC_TX_L3}, '{8'h01, 8'h33, 7'h0c, 7'h0c}};
   logic [7:0] ins_exp[4] = '{8'h13, 8'h07, 8'h11, 8'h11};

   ufc_flow ufc_flow_i (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_rx_count(rx_count), .i_rx_char(rx_char), .o_rx_store(rx_store), .i_cts_n(cts_n), .o_rts_n(rts_n),
      .o_cts_event(cts_event), .o_tx_go(tx_go), .o_ins(ins), .i_ins_taken(ins_taken), .o_irq_n(irq_n),
      .o_rx_trig(rx_trig), .o_tx_trig(tx_trig));
   ufc_remote ufc_remote_i (.i_clk(clk), .i_rts_n(rts_n), .i_ins(ins), .o_ins_taken(ins_taken),
      .o_cts_n(cts_n), .o_rx_char(rx_char));

   // clock and hang guard; a run past the ceiling counts as a mismatch
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   // remember pulses that the checks look at later
   always @(posedge clk) begin
      if (cts_event === 1'b1) evt_seen <= 1'b1;
      if (rx_store.valid === 1'b1) begin
         stored <= 1'b1;
         sdata <= rx_store.data;
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h00_0000, d}, r);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(nm, exp, r);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cnt_rts(input logic [6:0] v, input logic exp);
      @(posedge clk);
      rx_count <= v;
      tick(3);
      chk("rts_n", 32'(exp), 32'(rts_n));
   endtask
   task automatic xs(input logic [7:0] c, input logic exp);
      ufc_remote_i.send(c);
      tick(4);
      chk("tx_go", 32'(exp), 32'(tx_go));
   endtask
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      tick(2);
      chk("rx_trig", 32'(`UFC_ONE_CHAR), 32'(rx_trig));
      chk("tx_trig", 32'(`UFC_ONE_CHAR), 32'(tx_trig));
      chk("rts_n", 32'h0000_0001, 32'(rts_n));
      chk("irq_n", 32'h0000_0001, 32'(irq_n));
      rd("thld", `UFC_OFS_THLD, 32'h0000_0000);
      rd("ptrg", `UFC_OFS_PTRG, 32'h0000_0000);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, rx_count, evt_seen, stored, sdata} = '0;
      srst = 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      ufc_remote_i.set_cts(1'b0);
      do_reset();
      rd("iid", `UFC_OFS_IID, 32'(`UFC_IID_NONE));
      rd("lcr", `UFC_OFS_LCR, 32'(`UFC_LCR_RST));
      rd("unmapped", 8'h40, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, 32'(last_err));
      // trigger level table
      foreach (rows[k]) begin
         wr(`UFC_OFS_FCTL, rows[k].fctl);
         wr(`UFC_OFS_PTRG, rows[k].ptrg);
         tick(3);
         chk("rx_trig", 32'(rows[k].rx), 32'(rx_trig));
         chk("tx_trig", 32'(rows[k].tx), 32'(tx_trig));
      end
      // auto rts, zero thresholds fall back to selectable 16 with resume below 8
      wr(`UFC_OFS_PTRG, 8'h00);
      wr(`UFC_OFS_FCTL, 8'h41);
      wr(`UFC_OFS_MCTL, 8'h02);
      wr(`UFC_OFS_FEAT, 8'h40);
      cnt_rts(7'd15, 1'b0);
      cnt_rts(7'd16, 1'b1);
      cnt_rts(7'd8, 1'b1);
      cnt_rts(7'd7, 1'b0);
      wr(`UFC_OFS_THLD, 8'h35);
      cnt_rts(7'd19, 1'b0);
      cnt_rts(7'd20, 1'b1);
      stored = 1'b0;
      ufc_remote_i.send(8'h41);
      tick(3);
      chk("late char stored", 32'h0000_0141, {23'h00_0000, stored, sdata});
      cnt_rts(7'd13, 1'b1);
      cnt_rts(7'd12, 1'b0);
      // cts gating only with auto cts; host event only without it
      evt_seen = 1'b0;
      ufc_remote_i.set_cts(1'b1);
      tick(8);
      chk("tx_go", 32'h0000_0001, 32'(tx_go));
      chk("cts_event", 32'h0000_0001, 32'(evt_seen));
      wr(`UFC_OFS_FEAT, 8'hc0);
      tick(8);
      evt_seen = 1'b0;
      chk("tx_go", 32'h0000_0000, 32'(tx_go));
      ufc_remote_i.set_cts(1'b0);
      tick(8);
      chk("tx_go", 32'h0000_0001, 32'(tx_go));
      chk("cts_event", 32'h0000_0000, 32'(evt_seen));
      // in-band flow control; hardware flow control is switched off first
      wr(`UFC_OFS_FEAT, 8'h00);
      rx_count <= 7'd0;
      wr(`UFC_OFS_HC1, 8'h13);
      wr(`UFC_OFS_HC2, 8'h93);
      wr(`UFC_OFS_RC1, 8'h11);
      wr(`UFC_OFS_RC2, 8'h91);
      wr(`UFC_OFS_IEN, 8'h20);
      wr(`UFC_OFS_FEAT, 8'h0a);
      xs(8'h13, 1'b0);
      chk("irq_n", 32'h0000_0000, 32'(irq_n));
      rd("iid", `UFC_OFS_IID, 32'(`UFC_IID_OFF));
      xs(8'h11, 1'b1);
      chk("irq_n", 32'h0000_0001, 32'(irq_n));
      wr(`UFC_OFS_FEAT, 8'h01);
      xs(8'h13, 1'b1);
      xs(8'h93, 1'b0);
      xs(8'h91, 1'b1);
      wr(`UFC_OFS_FEAT, 8'h0b);
      xs(8'h93, 1'b0);
      xs(8'h11, 1'b1);
      wr(`UFC_OFS_FEAT, 8'h03);
      xs(8'h13, 1'b1);
      xs(8'h93, 1'b0);
      xs(8'h11, 1'b0);
      xs(8'h91, 1'b1);
      wr(`UFC_OFS_MCTL, 8'h20);
      wr(`UFC_OFS_FEAT, 8'h02);
      xs(8'h13, 1'b0);
      xs(8'h55, 1'b1);
      // any-char resume leaves the off interrupt pending; a real on char clears it
      xs(8'h11, 1'b1);
      chk("irq_n", 32'h0000_0001, 32'(irq_n));
      // special character: stored, no halt, cleared by reading the ident register
      wr(`UFC_OFS_MCTL, 8'h00);
      wr(`UFC_OFS_FEAT, 8'h20);
      stored = 1'b0;
      xs(8'h93, 1'b1);
      chk("special stored", 32'h0000_0193, {23'h00_0000, stored, sdata});
      chk("irq_n", 32'h0000_0000, 32'(irq_n));
      rd("iid", `UFC_OFS_IID, 32'(`UFC_IID_OFF));
      rd("iid", `UFC_OFS_IID, 32'(`UFC_IID_NONE));
      // both pairs sent in order, masked to a 5-bit word, with a slow taker
      wr(`UFC_OFS_FEAT, 8'h00);
      wr(`UFC_OFS_LCR, 8'h1c);
      wr(`UFC_OFS_HC1, 8'hf3);
      wr(`UFC_OFS_HC2, 8'he7);
      wr(`UFC_OFS_RC1, 8'hd1);
      wr(`UFC_OFS_RC2, 8'hb1);
      ufc_remote_i.got.delete();
      ufc_remote_i.lat = 3;
      wr(`UFC_OFS_FEAT, 8'h0c);
      cnt_rts(7'd20, 1'b1);
      tick(12);
      chk("ins count", 32'h0000_0000, 32'(ufc_remote_i.got.size()));
      cnt_rts(7'd21, 1'b1);
      tick(15);
      cnt_rts(7'd13, 1'b1);
      tick(12);
      chk("ins count", 32'h0000_0002, 32'(ufc_remote_i.got.size()));
      cnt_rts(7'd12, 1'b1);
      tick(15);
      chk("ins count", 32'h0000_0004, 32'(ufc_remote_i.got.size()));
      foreach (ins_exp[k]) begin
         chk("ins char", 32'(ins_exp[k]), 32'(ufc_remote_i.got[k]));
      end
      // second reset in mid-run clears thresholds again
      wr(`UFC_OFS_PTRG, 8'h33);
      do_reset();
      conclude();
   end
endmodule
